// File: pkg/mose_pkg.sv
// Shared constants and types for the opcode subset execution block
package mose_pkg;

    // Widths of program counter, data path and control-page index, and control-page register count
    localparam int PC_W = 11;
    localparam int DATA_W = 8;
    localparam int CP_IDX_W = 4;
    localparam int CP_DEPTH = 16;

    // Reset values
    localparam logic [PC_W-1:0] PC_RST = 11'h000;
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [DATA_W-1:0] CP_RST = 8'h00;

    // Trap vector and the legal control-page index range
    localparam logic [PC_W-1:0] TRAP_VEC = 11'h001;
    localparam logic [CP_IDX_W-1:0] CP_IDX_LO = 4'h5;
    localparam logic [CP_IDX_W-1:0] CP_IDX_HI = 4'hf;

    // Step sizes of the program counter and of the increment operation
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;
    localparam logic [PC_W-1:0] PC_SKIP_STEP = 11'h002;
    localparam logic [DATA_W-1:0] INC_STEP = 8'h01;

    // Cycle counts per operation
    localparam int TRAP_CYC = 3;
    localparam int JUMP_CYC = 2;
    localparam int SKIP_CYC = 2;
    localparam int SINGLE_CYC = 1;

    // Operation select codes on the op_code port
    typedef enum logic [2:0] {
        OP_TRAP = 3'h0,
        OP_OR_IMM = 3'h1,
        OP_OR_FILE = 3'h2,
        OP_WR_CP = 3'h3,
        OP_RD_CP = 3'h4,
        OP_LONG_JUMP = 3'h5,
        OP_INC_SKIP = 3'h6,
        OP_NONE = 3'h7
    } mose_op_t;

    // Sequencer states
    typedef enum {
        ST_IDLE,
        ST_TRAP2,
        ST_TRAP3,
        ST_JUMP2,
        ST_SKIP_NOP
    } mose_state_t;

endpackage

// File: pkg/mose_cp_if.sv
// Carrier between the sequencer and the control-page register file
`timescale 1ns/1ps
interface mose_cp_if;
    import mose_pkg::*;
    logic we; // Write strobe, one cycle
    logic [CP_IDX_W-1:0] idx; // Register index
    logic [DATA_W-1:0] wdata; // Write data
    logic [DATA_W-1:0] rdata; // Selected register contents

    modport core (output we, output idx, output wdata, input rdata);
    modport store (input we, input idx, input wdata, output rdata);
endinterface

// File: src/mose_cp_regs.sv
// Control-page special register file
`timescale 1ns/1ps
module mose_cp_regs
    import mose_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    mose_cp_if.store cp
);

    // Register array; reads look straight at the flops, no read latency
    logic [DATA_W-1:0] cp_reg [CP_DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // One flop group per register, loaded only on a matching strobe
    genvar g;
    generate
        for (g = 0; g < CP_DEPTH; g++) begin : g_cp
            always_ff @(posedge mclk) begin
                if (reset) begin
                    cp_reg[g] <= CP_RST;
                end else if (cp.we && cp.idx == CP_IDX_W'(g)) begin
                    cp_reg[g] <= cp.wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read selection; reading never disturbs the source register
    assign cp.rdata = cp_reg[cp.idx];

endmodule

// File: src/mose_exec.sv
// Execution sequencer for the opcode subset
// Summary of operation
// RULE_01: Zero increment result skips the next instruction.
// RULE_02: Skip runs a no-op; instruction takes two cycles.
// RULE_03: Trap pushes pc plus one, jumps 0x001, 3 cycles.
// RULE_04: OR immediate into working register, one cycle, zero.
// RULE_05: OR with file, destination by select bit.
// RULE_06: Working register to control page, flags untouched.
// RULE_07: Control page to working register, one cycle.
// RULE_08: Long jump loads 11-bit target, two cycles, no stack.
// RULE_09: Zero flag set exactly when result is zero.
`timescale 1ns/1ps
module mose_exec
    import mose_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [PC_W-1:0] op_operand,
    input wire logic op_dest,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic op_ready,
    output logic [PC_W-1:0] pc,
    output logic [DATA_W-1:0] working_register,
    output logic zero_flag,
    output logic [DATA_W-1:0] file_wdata,
    output logic file_we,
    output logic stack_push,
    output logic [PC_W-1:0] stack_data,
    output logic skip_nop
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    mose_state_t state_reg; // Sequencer state
    mose_state_t state_next; // Next sequencer state
    logic [PC_W-1:0] pc_reg; // Program counter
    logic [DATA_W-1:0] work_reg; // Working register
    logic zero_reg; // Zero flag
    logic [DATA_W-1:0] file_wdata_reg; // File write data
    logic file_we_reg; // File write strobe
    logic push_reg; // Stack push strobe
    logic [PC_W-1:0] push_data_reg; // Return address pushed
    logic take; // Operation accepted this cycle
    mose_op_t op; // Decoded select
    logic [DATA_W-1:0] imm8; // Low byte of the operand
    logic [DATA_W-1:0] or_imm_res; // OR immediate result
    logic [DATA_W-1:0] or_file_res; // OR with file result
    logic [DATA_W-1:0] inc_res; // Increment result
    logic cp_ok; // Control-page index in range

    mose_cp_if cp_bus ();

    // Index range check, used by both control-page transfers
    function automatic logic cp_in_range(input logic [CP_IDX_W-1:0] idx);
        cp_in_range = (idx >= CP_IDX_LO) && (idx <= CP_IDX_HI);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control-page register file
    mose_cp_regs u_cp (
        .mclk(mclk),
        .reset(reset),
        .cp(cp_bus.store)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode and datapath
    assign op = mose_op_t'(op_code);
    assign op_ready = (state_reg == ST_IDLE);
    assign take = op_valid && op_ready;
    assign imm8 = op_operand[DATA_W-1:0];
    assign or_imm_res = work_reg | imm8; // see RULE_04
    assign or_file_res = work_reg | file_rdata; // see RULE_05
    assign inc_res = file_rdata + INC_STEP;
    assign cp_ok = cp_in_range(op_operand[CP_IDX_W-1:0]);

    // Control-page strobe; indices below the range are dropped
    assign cp_bus.idx = op_operand[CP_IDX_W-1:0];
    assign cp_bus.wdata = work_reg; // see RULE_06
    assign cp_bus.we = take && (op == OP_WR_CP) && cp_ok; // see RULE_06

    ////////////////////////////////////////////////////////////////////////
    // Next state; multi-cycle operations hold op_ready low
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take && op == OP_TRAP) begin
                    state_next = ST_TRAP2; // see RULE_03
                end else if (take && op == OP_LONG_JUMP) begin
                    state_next = ST_JUMP2; // see RULE_08
                end else if (take && op == OP_INC_SKIP &&
                             inc_res == '0) begin
                    state_next = ST_SKIP_NOP; // see RULE_01
                end
            end
            ST_TRAP2: state_next = ST_TRAP3;
            ST_TRAP3: state_next = ST_IDLE;
            ST_JUMP2: state_next = ST_IDLE;
            ST_SKIP_NOP: state_next = ST_IDLE; // see RULE_02
            default: state_next = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter; all redirects happen at the accepting edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            pc_reg <= PC_RST;
        end else if (take) begin
            case (op)
                OP_TRAP: pc_reg <= TRAP_VEC; // see RULE_03
                OP_LONG_JUMP: pc_reg <= op_operand; // see RULE_08
                OP_INC_SKIP: begin
                    // Step over the fetched instruction on a zero result
                    if (inc_res == '0) begin
                        pc_reg <= pc_reg + PC_SKIP_STEP; // see RULE_01
                    end else begin
                        pc_reg <= pc_reg + PC_STEP;
                    end
                end
                default: pc_reg <= pc_reg + PC_STEP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Return stack push; only the trap uses it, the long jump never
    always_ff @(posedge mclk) begin
        if (reset) begin
            push_reg <= 1'b0;
            push_data_reg <= PC_RST;
        end else begin
            push_reg <= take && (op == OP_TRAP); // see RULE_03
            if (take && op == OP_TRAP) begin
                push_data_reg <= pc_reg + PC_STEP; // see RULE_03
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Working register
    always_ff @(posedge mclk) begin
        if (reset) begin
            work_reg <= WORK_RST;
        end else if (take) begin
            case (op)
                OP_OR_IMM: begin
                    work_reg <= or_imm_res; // see RULE_04
                end
                OP_OR_FILE: begin
                    if (!op_dest) begin
                        work_reg <= or_file_res; // see RULE_05
                    end
                end
                OP_RD_CP: begin
                    if (cp_ok) begin
                        work_reg <= cp_bus.rdata; // see RULE_07
                    end
                end
                OP_INC_SKIP: begin
                    if (!op_dest) begin
                        work_reg <= inc_res;
                    end
                end
                default: work_reg <= work_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Zero flag; only the two OR forms touch it
    always_ff @(posedge mclk) begin
        if (reset) begin
            zero_reg <= 1'b0;
        end else if (take && op == OP_OR_IMM) begin
            zero_reg <= (or_imm_res == '0); // see RULE_09
        end else if (take && op == OP_OR_FILE) begin
            zero_reg <= (or_file_res == '0); // see RULE_09
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // File write-back, one-cycle strobe after the accepting edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            file_we_reg <= 1'b0;
            file_wdata_reg <= WORK_RST;
        end else begin
            file_we_reg <= 1'b0;
            if (take && op_dest && op == OP_OR_FILE) begin
                file_we_reg <= 1'b1; // see RULE_05
                file_wdata_reg <= or_file_res;
            end else if (take && op_dest && op == OP_INC_SKIP) begin
                file_we_reg <= 1'b1;
                file_wdata_reg <= inc_res;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign pc = pc_reg;
    assign working_register = work_reg;
    assign zero_flag = zero_reg;
    assign file_wdata = file_wdata_reg;
    assign file_we = file_we_reg;
    assign stack_push = push_reg;
    assign stack_data = push_data_reg;
    assign skip_nop = (state_reg == ST_SKIP_NOP); // see RULE_02

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Checker copy of the index taken; the live index has moved on by then
    logic [CP_IDX_W-1:0] cp_idx_chk_reg; // Index seen at the last edge
    logic [DATA_W-1:0] cp_held; // That register one cycle later
    always_ff @(posedge mclk) begin
        cp_idx_chk_reg <= cp_bus.idx;
    end
    assign cp_held = u_cp.cp_reg[cp_idx_chk_reg];

    property p_skip_nop;
        take && op == OP_INC_SKIP && inc_res == '0 |=> skip_nop;
    endproperty
    a_skip_nop: assert property (p_skip_nop) // see RULE_01
        else $error("skip did not run a no-op");
    property p_skip_len;
        take && op == OP_INC_SKIP && inc_res == '0 |=>
            !op_ready ##1 op_ready;
    endproperty
    a_skip_len: assert property (p_skip_len) // see RULE_02
        else $error("skipping instruction not two cycles");
    property p_trap;
        take && op == OP_TRAP |=> stack_push &&
            stack_data == $past(pc) + PC_STEP && pc == TRAP_VEC;
    endproperty
    a_trap: assert property (p_trap) // see RULE_03
        else $error("trap push or vector wrong");
    property p_trap_len;
        take && op == OP_TRAP |=> !op_ready [*2] ##1 op_ready;
    endproperty
    a_trap_len: assert property (p_trap_len) // see RULE_03
        else $error("trap not three cycles");
    property p_or_imm;
        take && op == OP_OR_IMM |=> op_ready &&
            working_register == ($past(working_register) | $past(imm8));
    endproperty
    a_or_imm: assert property (p_or_imm) // see RULE_04
        else $error("or immediate result wrong");
    property p_or_file;
        take && op == OP_OR_FILE && op_dest |=> file_we &&
            file_wdata == ($past(work_reg) | $past(file_rdata)) &&
            $stable(working_register);
    endproperty
    a_or_file: assert property (p_or_file) // see RULE_05
        else $error("or with file write-back wrong");
    property p_wr_cp;
        take && op == OP_WR_CP && cp_ok |=> $stable(zero_flag) &&
            op_ready && cp_held == $past(work_reg);
    endproperty
    a_wr_cp: assert property (p_wr_cp) // see RULE_06
        else $error("control page write wrong");
    property p_rd_cp;
        take && op == OP_RD_CP && cp_ok |=> op_ready &&
            working_register == $past(cp_bus.rdata) &&
            cp_held == $past(cp_bus.rdata);
    endproperty
    a_rd_cp: assert property (p_rd_cp) // see RULE_07
        else $error("control page read wrong");
    property p_jump;
        take && op == OP_LONG_JUMP |=> pc == $past(op_operand) &&
            !stack_push && !op_ready ##1 op_ready;
    endproperty
    a_jump: assert property (p_jump) // see RULE_08
        else $error("long jump wrong");
    property p_zero;
        take && (op == OP_OR_IMM || (op == OP_OR_FILE && !op_dest)) |=>
            zero_flag == (working_register == '0);
    endproperty
    a_zero: assert property (p_zero) // see RULE_09
        else $error("zero flag disagrees with result");

endmodule

// File: test/mcu_opcode_subset_exec_tb_top.sv
// Self-checking testbench for the opcode subset execution sequencer
`timescale 1ns/1ps
module mcu_opcode_subset_exec_tb_top;
    import mose_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Stimulus, observation and bookkeeping
    logic mclk; // Core clock, 40 ns
    logic reset; // Synchronous, active high
    logic op_valid;
    logic [2:0] op_code;
    logic [PC_W-1:0] op_operand;
    logic op_dest;
    logic [DATA_W-1:0] file_rdata;
    logic op_ready;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] working_register;
    logic zero_flag;
    logic [DATA_W-1:0] file_wdata;
    logic file_we;
    logic stack_push;
    logic [PC_W-1:0] stack_data;
    logic skip_nop;
    int fails; // Mismatch count
    int tests_run; // Comparison count
    int stalls; // Cycles op_ready stayed low after a take
    logic [PC_W-1:0] exp_pc; // Program counter as the bench predicts it
    // Snapshot of the cycle right after the take edge
    logic [DATA_W-1:0] s_w;
    logic [DATA_W-1:0] s_wd;
    logic [PC_W-1:0] s_sd;
    logic s_z, s_we, s_push, s_skip;

    mose_exec dut (
        .mclk(mclk), .reset(reset), .op_valid(op_valid),
        .op_code(op_code), .op_operand(op_operand), .op_dest(op_dest),
        .file_rdata(file_rdata), .op_ready(op_ready), .pc(pc),
        .working_register(working_register), .zero_flag(zero_flag),
        .file_wdata(file_wdata), .file_we(file_we),
        .stack_push(stack_push), .stack_data(stack_data),
        .skip_nop(skip_nop)
    );

    // Free-running core clock
    always #20 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    // Comparison and closing tasks
    task automatic chk_val(input logic [PC_W-1:0] got,
                           input logic [PC_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One request; entered just after an edge with op_ready high.
    // Valid stays up after a one-cycle op so back-to-back ops need no
    // second assignment in one time step.
    task automatic do_op(input mose_op_t c, input logic [PC_W-1:0] opr,
                         input logic d, input logic [DATA_W-1:0] fr,
                         input logic [PC_W-1:0] npc, input int nst);
        op_code = c;
        op_operand = opr;
        op_dest = d;
        file_rdata = fr;
        op_valid = 1'b1;
        @(posedge mclk);
        #1;
        s_w = working_register;
        s_z = zero_flag;
        s_we = file_we;
        s_wd = file_wdata;
        s_push = stack_push;
        s_sd = stack_data;
        s_skip = skip_nop;
        chk_val(pc, npc);
        stalls = 0;
        // Drop the request only while stalled, so it is not taken twice
        if (op_ready !== 1'b1) begin
            op_valid = 1'b0;
        end
        while (op_ready !== 1'b1 && stalls < 10) begin
            @(posedge mclk);
            #1;
            stalls++;
        end
        if (stalls >= 10) begin
            fails++;
            end_of_test();
        end
        chk_val(PC_W'(stalls), PC_W'(nst));
        exp_pc = npc;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    // Control-page traffic, including out-of-range indices
    task automatic t_ctrl_page();
        do_op(OP_RD_CP, 11'h005, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_val(s_w, 8'h00);
        do_op(OP_OR_IMM, 11'h000, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_bit(s_z, 1'b1);
        do_op(OP_WR_CP, 11'h007, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_bit(s_z, 1'b1);
        do_op(OP_OR_IMM, 11'h03c, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_bit(s_z, 1'b0);
        do_op(OP_WR_CP, 11'h005, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_bit(s_z, 1'b0);
        do_op(OP_OR_IMM, 11'h0c3, 1'b0, 8'h00, exp_pc + 1, 0);
        do_op(OP_WR_CP, 11'h00f, 1'b0, 8'h00, exp_pc + 1, 0);
        do_op(OP_WR_CP, 11'h004, 1'b0, 8'h00, exp_pc + 1, 0);
        do_op(OP_RD_CP, 11'h004, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_val(s_w, 8'hff);
        do_op(OP_RD_CP, 11'h005, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_val(s_w, 8'h3c);
        do_op(OP_RD_CP, 11'h005, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_val(s_w, 8'h3c);
        do_op(OP_RD_CP, 11'h00f, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_val(s_w, 8'hff);
    endtask

    // OR immediate and OR with file, both destinations
    task automatic t_or_ops();
        do_op(OP_RD_CP, 11'h006, 1'b0, 8'h00, exp_pc + 1, 0);
        do_op(OP_OR_FILE, 11'h000, 1'b1, 8'h00, exp_pc + 1, 0);
        chk_bit(s_we, 1'b1);
        chk_val(s_wd, 8'h00);
        chk_bit(s_z, 1'b1);
        do_op(OP_OR_IMM, 11'h0aa, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_val(s_w, 8'haa);
        chk_bit(s_z, 1'b0);
        do_op(OP_OR_IMM, 11'h050, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_val(s_w, 8'hfa);
        do_op(OP_OR_FILE, 11'h000, 1'b1, 8'h05, exp_pc + 1, 0);
        chk_bit(s_we, 1'b1);
        chk_val(s_wd, 8'hff);
        chk_val(s_w, 8'hfa);
        do_op(OP_OR_FILE, 11'h000, 1'b0, 8'h05, exp_pc + 1, 0);
        chk_bit(s_we, 1'b0);
        chk_val(s_w, 8'hff);
    endtask

    // Trap and long jump redirect the program counter
    task automatic t_branches();
        logic [PC_W-1:0] ret;
        ret = exp_pc + 1;
        do_op(OP_TRAP, 11'h000, 1'b0, 8'h00, TRAP_VEC, 2);
        chk_bit(s_push, 1'b1);
        chk_val(s_sd, ret);
        do_op(OP_LONG_JUMP, 11'h7ff, 1'b0, 8'h00, 11'h7ff, 1);
        chk_bit(s_push, 1'b0);
        do_op(OP_LONG_JUMP, 11'h2a5, 1'b0, 8'h00, 11'h2a5, 1);
        chk_bit(s_push, 1'b0);
    endtask

    // Increment and skip: zero result both ways, then no skip
    task automatic t_inc_skip();
        do_op(OP_INC_SKIP, 11'h000, 1'b0, 8'hff, exp_pc + 2, 1);
        chk_val(s_w, 8'h00);
        chk_bit(s_skip, 1'b1);
        do_op(OP_INC_SKIP, 11'h000, 1'b1, 8'hff, exp_pc + 2, 1);
        chk_bit(s_we, 1'b1);
        chk_val(s_wd, 8'h00);
        chk_bit(s_skip, 1'b1);
        do_op(OP_INC_SKIP, 11'h000, 1'b0, 8'h10, exp_pc + 1, 0);
        chk_val(s_w, 8'h11);
        chk_bit(s_skip, 1'b0);
        chk_bit(s_z, 1'b0);
        do_op(OP_NONE, 11'h0ff, 1'b0, 8'h00, exp_pc + 1, 0);
        chk_val(s_w, 8'h11);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for five cycles, then every scenario
    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        op_valid = 1'b0;
        op_code = 3'h7;
        op_operand = 11'h000;
        op_dest = 1'b0;
        file_rdata = 8'h00;
        fails = 0;
        tests_run = 0;
        exp_pc = PC_RST;
        repeat (5) @(posedge mclk);
        #1;
        reset = 1'b0;
        chk_val(pc, PC_RST);
        chk_val(working_register, WORK_RST);
        chk_bit(zero_flag, 1'b0);
        chk_bit(op_ready, 1'b1);
        t_ctrl_page();
        t_or_ops();
        t_branches();
        t_inc_skip();
        op_valid = 1'b0;
        repeat (2) @(posedge mclk);
        end_of_test();
    end
endmodule
